// *** logic/pvis_top.sv ***
// Interrupt status, routing and VME software interrupt enable logic of the bridge, with its AXI4-Lite register port.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R1] Four location monitor bits, set on event, W1C
// [R2] Four mailbox bits, set on event, W1C
// [R3] Status bits latch on source edges
// [R4] Writing one clears regardless of source; here the power and system fail bits stay set while their pin is high
// [R5] Software must service sources separately
// [R6] Power and system fail follow pins; here they set on the level and stay set after the pin falls until W1C
// [R7] Soft interrupt and soft acknowledge status bits
// [R8] VME error, PCI error, DMA status bits
// [R9] VME levels and ownership status bits
// [R10] Route A holds level destinations
// [R11] Route A holds ownership destination
// [R12] Route B holds remaining source destinations; mailbox and location monitor bits here go to fixed output 0 instead
// [R13] Three-bit binary destination output number
// [R14] VME enable bits seven to three
// [R15] Enable rise raises VME soft interrupt
// [R16] Enable fall masks, status kept
// [R17] Acknowledge stores vector, sets status, stalls level
// [R18] PCI enable bit gates each source
// [R19] Output asserted while routed source active
module pvis_top (
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // AXI4-Lite write channels.
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt sources, active high.
  input wire logic [3:0] loc_monitor_in,
  input wire logic [3:0] mailbox_in,
  input wire logic power_fail_in,
  input wire logic sys_fail_in,
  input wire logic soft_ack_event,
  input wire logic vme_bus_error,
  input wire logic pci_bus_error,
  input wire logic dma_done,
  input wire logic vme_ownership_event,
  // VME interrupt handler side.
  input wire logic [7:1] vme_irq_levels,
  input wire logic [7:1] iack_done,
  input wire logic [7:0] iack_vector,
  output logic [7:1] iack_req,
  // Interrupt outputs.
  output logic [7:0] pci_irq_out_n,
  output logic [7:3] vme_soft_irq
);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  pvis_regbus_if bus ();

  pvis_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .bus(bus)
  );

  // Expands byte strobes to a bit mask.
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    for (int i = 0; i < pvis_pkg::STRB_W; i++) begin
      strb_mask[i * 8 +: 8] = {8{strb[i]}};
    end
  endfunction : strb_mask

  // Merges written bytes into a read-write register, keeping reserved bits at zero.
  function automatic logic [31:0] merge_wr(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = strb_mask(strb);
    merge_wr = ((old & ~m) | (data & m)) & mask;
  endfunction : merge_wr

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0] en_r, route_a_r, route_b_r, vme_en_r, stat_r, vsoft_r, src_prev_r, vme_en_prev_r;
  logic [7:0] vec_r [pvis_pkg::BIT_VIRQ1:pvis_pkg::BIT_VIRQ7];
  logic [7:1] iack_req_r;
  logic [7:0] pci_out_n_r;
  logic [4:0] vme_soft_irq_r;
  logic [7:0] route_level;

  // Address decode.
  wire wr_pci_en = bus.wr_en && (bus.wr_addr == pvis_pkg::OFF_PCI_EN);
  wire wr_stat = bus.wr_en && (bus.wr_addr == pvis_pkg::OFF_STAT);
  wire wr_route_a = bus.wr_en && (bus.wr_addr == pvis_pkg::OFF_ROUTE_A);
  wire wr_route_b = bus.wr_en && (bus.wr_addr == pvis_pkg::OFF_ROUTE_B);
  wire wr_vme_en = bus.wr_en && (bus.wr_addr == pvis_pkg::OFF_VME_EN);
  wire wr_vstat = bus.wr_en && (bus.wr_addr == pvis_pkg::OFF_VME_STAT);
  wire [2:0] vec_slot = bus.rd_addr[4:2];
  wire rd_vec = (bus.rd_addr[11:5] == pvis_pkg::OFF_VEC_BASE[11:5]) && (bus.rd_addr[1:0] == 2'h0)
                && (vec_slot != pvis_pkg::VEC_SLOT_NONE);
  wire [31:0] wr_bits = bus.wr_data & strb_mask(bus.wr_strb);

  // ****************************************************************
  // Status latching
  // ****************************************************************
  // Source levels in status-bit order; the soft interrupt source is the enable bit itself.
  wire [31:0] src_lvl = {8'h00, loc_monitor_in, mailbox_in, power_fail_in, sys_fail_in,
                         en_r[pvis_pkg::BIT_SWI], soft_ack_event, 1'b0, vme_bus_error, pci_bus_error,
                         dma_done, iack_done, vme_ownership_event};
  // Edge bits latch on a rising source; the two fail bits set on the level. A set beats a clear.
  wire [31:0] stat_set = ((src_lvl & ~src_prev_r & ~pvis_pkg::LEVEL_MASK)
                         | (src_lvl & pvis_pkg::LEVEL_MASK)) & pvis_pkg::STAT_MASK; // R1 R2 R3 R6 R7 R8 R9
  wire [31:0] stat_clr = wr_stat ? wr_bits : pvis_pkg::REG_RESET; // R4
  wire [31:0] stat_nxt = ((stat_r & ~stat_clr) | stat_set) & pvis_pkg::STAT_MASK; // R4 R6

  // VME software levels: an enable rise sets the status; a clear of the enable leaves it.
  wire [31:0] vme_en_nxt = wr_vme_en ? merge_wr(vme_en_r, bus.wr_data, bus.wr_strb, pvis_pkg::VME_EN_MASK)
                                     : vme_en_r; // R14
  wire [31:0] vme_rise = vme_en_r & ~vme_en_prev_r & pvis_pkg::VME_EN_MASK; // R15
  wire [31:0] vsoft_clr = wr_vstat ? wr_bits : pvis_pkg::REG_RESET;
  wire [31:0] vsoft_nxt = ((vsoft_r & ~vsoft_clr) | vme_rise) & pvis_pkg::VME_EN_MASK; // R16
  wire [31:0] vsoft_on = vsoft_nxt & vme_en_nxt;
  wire [4:0] vme_soft_nxt = vsoft_on[pvis_pkg::VME_SOFT_LSB +: pvis_pkg::VME_SOFT_N]; // R15 R16

  // A level is requested only while enabled and not already pending, so no second vector is fetched.
  wire [7:1] iack_req_nxt = vme_irq_levels & en_r[pvis_pkg::BIT_VIRQ7:pvis_pkg::BIT_VIRQ1]
                            & ~stat_nxt[pvis_pkg::BIT_VIRQ7:pvis_pkg::BIT_VIRQ1]; // R17

  // Register file updates.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= pvis_pkg::REG_RESET;
      route_a_r <= pvis_pkg::REG_RESET;
      route_b_r <= pvis_pkg::REG_RESET;
      vme_en_r <= pvis_pkg::REG_RESET;
      vme_en_prev_r <= pvis_pkg::REG_RESET;
      stat_r <= pvis_pkg::REG_RESET;
      vsoft_r <= pvis_pkg::REG_RESET;
      src_prev_r <= pvis_pkg::REG_RESET;
    end else if (aclken) begin
      if (wr_pci_en) begin
        en_r <= merge_wr(en_r, bus.wr_data, bus.wr_strb, pvis_pkg::STAT_MASK); // R18
      end
      if (wr_route_a) begin
        route_a_r <= merge_wr(route_a_r, bus.wr_data, bus.wr_strb, pvis_pkg::ROUTE_A_MASK); // R10 R11
      end
      if (wr_route_b) begin
        route_b_r <= merge_wr(route_b_r, bus.wr_data, bus.wr_strb, pvis_pkg::ROUTE_B_MASK); // R12
      end
      vme_en_r <= vme_en_nxt;
      vme_en_prev_r <= vme_en_r;
      stat_r <= stat_nxt;
      vsoft_r <= vsoft_nxt;
      src_prev_r <= src_lvl;
    end
  end

  // Vector store, written when the acknowledge cycle of a level completes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int l = pvis_pkg::BIT_VIRQ1; l <= pvis_pkg::BIT_VIRQ7; l++) begin
        vec_r[l] <= '0;
      end
    end else if (aclken) begin
      for (int l = pvis_pkg::BIT_VIRQ1; l <= pvis_pkg::BIT_VIRQ7; l++) begin
        if (iack_done[l]) begin
          vec_r[l] <= iack_vector; // R17
        end
      end
    end
  end

  // ****************************************************************
  // Routing and registered outputs
  // ****************************************************************
  pvis_irq_router u_router (
    .stat(stat_r),
    .en(en_r),
    .route_a(route_a_r),
    .route_b(route_b_r),
    .level(route_level)
  );

  // Outputs are registered; the PCI outputs lag stat_r by one enabled cycle, while iack_req and vme_soft_irq take the next status and update with it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_out_n_r <= pvis_pkg::PCI_OUT_IDLE;
      iack_req_r <= '0;
      vme_soft_irq_r <= '0;
    end else if (aclken) begin
      pci_out_n_r <= ~route_level; // R18 R19
      iack_req_r <= iack_req_nxt;
      vme_soft_irq_r <= vme_soft_nxt;
    end
  end

  assign pci_irq_out_n = pci_out_n_r;
  assign iack_req = iack_req_r;
  assign vme_soft_irq = vme_soft_irq_r;

  // ****************************************************************
  // Read mux and write answer
  // ****************************************************************
  // Unmapped or misaligned addresses answer with an error; vectors are read-only.
  assign bus.rd_ok = (bus.rd_addr == pvis_pkg::OFF_PCI_EN) || (bus.rd_addr == pvis_pkg::OFF_STAT)
                     || (bus.rd_addr == pvis_pkg::OFF_ROUTE_A) || (bus.rd_addr == pvis_pkg::OFF_ROUTE_B)
                     || (bus.rd_addr == pvis_pkg::OFF_VME_EN) || (bus.rd_addr == pvis_pkg::OFF_VME_STAT) || rd_vec;
  assign bus.wr_ok = wr_pci_en || wr_stat || wr_route_a || wr_route_b || wr_vme_en || wr_vstat;
  assign bus.rd_data = (bus.rd_addr == pvis_pkg::OFF_PCI_EN) ? en_r :
                       (bus.rd_addr == pvis_pkg::OFF_STAT) ? stat_r :
                       (bus.rd_addr == pvis_pkg::OFF_ROUTE_A) ? route_a_r :
                       (bus.rd_addr == pvis_pkg::OFF_ROUTE_B) ? route_b_r :
                       (bus.rd_addr == pvis_pkg::OFF_VME_EN) ? vme_en_r :
                       (bus.rd_addr == pvis_pkg::OFF_VME_STAT) ? vsoft_r :
                       rd_vec ? {24'h000000, vec_r[3'(vec_slot + 3'h1)]} : pvis_pkg::REG_RESET;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lm_edge_set: assert property (aclken && loc_monitor_in[0] && !src_prev_r[pvis_pkg::BIT_LM0] // R1
    |=> stat_r[pvis_pkg::BIT_LM0]) else $error("location monitor edge not latched");
  a_mbox_edge_set: assert property (aclken && mailbox_in[3] && !src_prev_r[pvis_pkg::BIT_MAILBOX_0 + 3] // R2
    |=> stat_r[pvis_pkg::BIT_MAILBOX_0 + 3]) else $error("mailbox edge not latched");
  a_edge_holds_set: assert property (aclken && stat_r[pvis_pkg::BIT_LM0] && !stat_clr[pvis_pkg::BIT_LM0] // R3
    ##1 !loc_monitor_in[0] |-> stat_r[pvis_pkg::BIT_LM0]) else $error("edge status followed the source level");
  a_w1c_clears: assert property (aclken |=> // R4
    (stat_r & $past(stat_clr) & ~$past(stat_set)) == 32'h00000000) else $error("written one did not clear status");
  a_fail_level_hold: assert property (aclken && (power_fail_in || sys_fail_in) |=> // R6
    (stat_r[pvis_pkg::BIT_PWR] || !$past(power_fail_in)) && (stat_r[pvis_pkg::BIT_SYS] || !$past(sys_fail_in)))
    else $error("fail status dropped while pin asserted");
  a_soft_int_rise: assert property (aclken && en_r[pvis_pkg::BIT_SWI] && !src_prev_r[pvis_pkg::BIT_SWI] // R7
    |=> stat_r[pvis_pkg::BIT_SWI]) else $error("soft interrupt enable rise not latched");
  a_dma_edge_set: assert property (aclken && dma_done && !src_prev_r[pvis_pkg::BIT_DMA] // R8
    |=> stat_r[pvis_pkg::BIT_DMA]) else $error("DMA edge not latched");
  a_iack_stores_vec: assert property (aclken && iack_done[3] |=> stat_r[pvis_pkg::BIT_VIRQ3] // R9 R17
    && vec_r[3] == $past(iack_vector)) else $error("acknowledge did not set status or store vector");
  a_no_refetch: assert property ((stat_r[pvis_pkg::BIT_VIRQ7:pvis_pkg::BIT_VIRQ1] & iack_req_r) == 7'h00) // R17
    else $error("level requested while its status is pending");
  a_own_route: assert property (aclken && stat_r[pvis_pkg::BIT_VME_OWNERSHIP_EVENT] && en_r[pvis_pkg::BIT_VME_OWNERSHIP_EVENT] // R10 R11 R13
    |=> !pci_irq_out_n[$past(route_a_r[2:0])]) else $error("ownership not on its routed output");
  a_dma_route: assert property (aclken && stat_r[pvis_pkg::BIT_DMA] && en_r[pvis_pkg::BIT_DMA] // R12 R13
    |=> !pci_irq_out_n[$past(route_b_r[2:0])]) else $error("DMA not on its routed output");
  a_enable_gates: assert property (aclken && en_r == 32'h00000000 // R18 R19
    |=> pci_irq_out_n == pvis_pkg::PCI_OUT_IDLE) else $error("output asserted with all sources masked");
  a_vme_en_write: assert property (aclken && wr_vme_en && bus.wr_strb == 4'hF // R14
    |=> vme_en_r == ($past(bus.wr_data) & pvis_pkg::VME_EN_MASK)) else $error("VME enable write lost");
  a_soft_vme_gen: assert property (aclken && vme_rise[31] ##1 aclken && vme_en_nxt[31] && !vsoft_clr[31] // R15
    |=> vme_soft_irq[7]) else $error("enable rise did not raise VME soft level");
  a_mask_keeps: assert property (aclken && vsoft_r[31] && !vsoft_clr[31] && !vme_en_nxt[31] // R16
    |=> vsoft_r[31] && !vme_soft_irq[7]) else $error("masking changed status or left level asserted");

  c_virq_ack: cover property (aclken && iack_req_r[5] ##[1:20] iack_done[5]);
  c_set_and_clear: cover property (aclken && (stat_set & stat_clr) != 32'h00000000);
  c_soft_vme: cover property (vme_soft_irq[3] ##1 !vme_soft_irq[3]);
  c_pci_out: cover property (pci_irq_out_n[6] ##1 !pci_irq_out_n[6]);

endmodule : pvis_top

`default_nettype wire

// *** logic/pvis_pkg.sv ***
// Package with the register map, field layout and bus constants of the interrupt status and routing block.
package pvis_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int NUM_OUT = 8;
  localparam int NUM_SRC = 24;
  localparam int ROUTE_W = 3;
  localparam int ROUTE_STRIDE = 4;
  localparam int ROUTE_B_BASE = 8;
  localparam int VEC_W = 8;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFF_PCI_EN = 12'h300;
  localparam logic [11:0] OFF_STAT = 12'h304;
  localparam logic [11:0] OFF_ROUTE_A = 12'h308;
  localparam logic [11:0] OFF_ROUTE_B = 12'h30C;
  localparam logic [11:0] OFF_VME_EN = 12'h310;
  localparam logic [11:0] OFF_VME_STAT = 12'h314;
  localparam logic [11:0] OFF_VEC_BASE = 12'h320;
  localparam logic [2:0] VEC_SLOT_NONE = 3'h7;

  // ****************************************************************
  // Field layout, writable masks and reset values
  // ****************************************************************
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [31:0] STAT_MASK = 32'h00FFF7FF;
  localparam logic [31:0] LEVEL_MASK = 32'h0000C000;
  localparam logic [31:0] ROUTE_A_MASK = 32'h77777777;
  localparam logic [31:0] ROUTE_B_MASK = 32'h77770777;
  localparam logic [31:0] VME_EN_MASK = 32'hF8000000;
  localparam int BIT_MAILBOX_0 = 16;
  localparam int BIT_LM0 = 20;
  localparam int BIT_PWR = 15;
  localparam int BIT_SYS = 14;
  localparam int BIT_SWI = 13;
  localparam int BIT_DMA = 8;
  localparam int BIT_VIRQ1 = 1;
  localparam int BIT_VIRQ3 = 3;
  localparam int BIT_VIRQ7 = 7;
  localparam int BIT_VME_OWNERSHIP_EVENT = 0;
  localparam int VME_SOFT_LSB = 27;
  localparam int VME_SOFT_N = 5;
  localparam logic [2:0] DEST_FIXED = 3'h0;
  localparam logic [7:0] PCI_OUT_IDLE = 8'hFF;

  // ****************************************************************
  // Response codes
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pvis_pkg

// *** logic/pvis_regbus_if.sv ***
// Interface that carries register reads and writes from the bus slave to the register file.
`timescale 1ns/1ps
`default_nettype none

interface pvis_regbus_if;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  // The slave side issues one-cycle strobes; the register side answers in the same cycle.
  modport slave_side (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
  modport regs_side (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface : pvis_regbus_if

`default_nettype wire

// *** logic/pvis_axil_slave.sv ***
// AXI4-Lite slave that turns bus transfers into single-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none

module pvis_axil_slave (
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // Write channels.
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels.
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side.
  pvis_regbus_if.slave_side bus
);

  logic awready_r, arready_r, bvalid_r, rvalid_r, wr_en_r, rd_en_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wdata_r;
  logic [11:0] waddr_r, raddr_r;
  logic [3:0] wstrb_r;

  // Address and data are waited for together, so either arrival order works and one write runs at a time.
  wire wr_start = awvalid && wvalid && !awready_r && !wr_en_r && !bvalid_r;
  wire wr_take = awready_r && awvalid && wvalid;
  wire rd_start = arvalid && !arready_r && !rd_en_r && !rvalid_r;
  wire rd_take = arready_r && arvalid;

  // Handshake sequencing for both directions.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      wr_en_r <= 1'b0;
      rd_en_r <= 1'b0;
      bresp_r <= pvis_pkg::RESP_OKAY;
      rresp_r <= pvis_pkg::RESP_OKAY;
      rdata_r <= pvis_pkg::REG_RESET;
      wdata_r <= pvis_pkg::REG_RESET;
      waddr_r <= '0;
      raddr_r <= '0;
      wstrb_r <= '0;
    end else if (aclken) begin
      wr_en_r <= wr_take;
      rd_en_r <= rd_take;
      if (wr_start) begin
        awready_r <= 1'b1;
      end else if (wr_take) begin
        awready_r <= 1'b0;
        waddr_r <= awaddr;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_en_r) begin
        bvalid_r <= 1'b1;
        bresp_r <= bus.wr_ok ? pvis_pkg::RESP_OKAY : pvis_pkg::RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_start) begin
        arready_r <= 1'b1;
      end else if (rd_take) begin
        arready_r <= 1'b0;
        raddr_r <= araddr;
      end
      if (rd_en_r) begin
        rvalid_r <= 1'b1;
        rdata_r <= bus.rd_data;
        rresp_r <= bus.rd_ok ? pvis_pkg::RESP_OKAY : pvis_pkg::RESP_SLVERR;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Outputs come straight from the flops above.
  assign awready = awready_r;
  assign wready = awready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign bus.wr_en = wr_en_r;
  assign bus.wr_addr = waddr_r;
  assign bus.wr_data = wdata_r;
  assign bus.wr_strb = wstrb_r;
  assign bus.rd_en = rd_en_r;
  assign bus.rd_addr = raddr_r;

endmodule : pvis_axil_slave

`default_nettype wire

// *** logic/pvis_irq_router.sv ***
// Router that folds every enabled, pending source onto its selected PCI interrupt output, or onto fixed output 0 for mailbox and location monitor sources.
`timescale 1ns/1ps
`default_nettype none

module pvis_irq_router (
  // Pending and enable vectors.
  input wire logic [31:0] stat,
  input wire logic [31:0] en,
  // Destination fields.
  input wire logic [31:0] route_a,
  input wire logic [31:0] route_b,
  // Active-high output levels.
  output logic [7:0] level
);

  // Sources without a destination field are sent to a fixed output.
  function automatic logic [2:0] dest_of(input int s, input logic [31:0] ra, input logic [31:0] rb);
    if (s < pvis_pkg::ROUTE_B_BASE) begin
      dest_of = ra[s * pvis_pkg::ROUTE_STRIDE +: pvis_pkg::ROUTE_W];
    end else if (s < 2 * pvis_pkg::ROUTE_B_BASE) begin
      dest_of = rb[(s - pvis_pkg::ROUTE_B_BASE) * pvis_pkg::ROUTE_STRIDE +: pvis_pkg::ROUTE_W];
    end else begin
      dest_of = pvis_pkg::DEST_FIXED;
    end
  endfunction : dest_of

  wire [31:0] active = stat & en;

  // An output is high while any source that selects it is pending and enabled.
  always_comb begin
    level = '0;
    for (int s = 0; s < pvis_pkg::NUM_SRC; s++) begin
      if (active[s]) begin
        level[dest_of(s, route_a, route_b)] = 1'b1; // R13 R19
      end
    end
  end

endmodule : pvis_irq_router

`default_nettype wire

// *** verification/pvis_iack_model.sv ***
// Behavioural VME interrupt handler that answers acknowledge requests.
`timescale 1ns/1ps
`default_nettype none
module pvis_iack_model (
  // Clock and requests.
  input wire logic aclk,
  input wire logic [7:1] iack_req,
  // Answer.
  output var logic [7:1] iack_done,
  output var logic [7:0] iack_vector
);
  logic [1:0] dly_r = 2'h0;
  // Answers the lowest level after a wait; the vector toggles outside the pulse so it is never trusted stale.
  always @(posedge aclk) begin
    iack_done <= 7'h00;
    iack_vector <= ~iack_vector;
    dly_r <= (iack_req != 7'h00 && iack_done == 7'h00) ? dly_r + 2'h1 : 2'h0;
    if (dly_r == 2'h3) begin
      iack_done <= iack_req & (~iack_req + 7'h01);
      iack_vector <= {1'b1, iack_req & (~iack_req + 7'h01)};
    end
  end
  initial iack_done = 7'h00;
  initial iack_vector = 8'h00;
endmodule : pvis_iack_model
`default_nettype wire

// *** verification/pci_vme_interrupt_status_map_test.sv ***
// Self-checking bench for the interrupt status and routing block.
`timescale 1ns/1ps
`default_nettype none
module pci_vme_interrupt_status_map_test;
  logic aclk = '0, aresetn = '0, aclken = '1, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, v, r;
  logic [3:0] wstrb = 4'hF, loc_monitor_in = '0, mailbox_in = '0;
  logic [1:0] bresp, rresp, rs, bs;
  logic awready, wready, bvalid, arready, rvalid, power_fail_in = '0, sys_fail_in = '0, soft_ack_event = '0;
  logic vme_bus_error = '0, pci_bus_error = '0, dma_done = '0, vme_ownership_event = '0;
  logic [7:1] vme_irq_levels = '0, iack_done, iack_req;
  logic [7:0] iack_vector, pci_irq_out_n;
  logic [7:3] vme_soft_irq;
  logic [2:0] d;
  int errors = 0, comparisons = 0, cyc = 0;
  pvis_top DUT (.aclk, .aresetn, .aclken, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .loc_monitor_in,
    .mailbox_in, .power_fail_in, .sys_fail_in, .soft_ack_event, .vme_bus_error, .pci_bus_error, .dma_done,
    .vme_ownership_event, .vme_irq_levels, .iack_done, .iack_vector, .iack_req, .pci_irq_out_n, .vme_soft_irq);
  pvis_iack_model handler (.aclk, .iack_req, .iack_done, .iack_vector);
  // Clock and hang guard; the tests need well under a thousand cycles.
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // A clock edge passes first so a released strobe is never raised again in the same step.
  // Address and data channels are each released at the edge where their own ready is seen.
  task automatic wr(input logic [11:0] a, input logic [31:0] dt);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= dt; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready === 1'b1) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bs = bresp; bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata; rs = rresp; rready <= 1'b0;
  endtask : rd
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial begin
    void'($urandom(95334));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(12'h300 + 12'(4 * a)); chk(v, 32'h00000000);
    end
    rd(12'h3FC); chk({30'h0, rs}, {30'h0, pvis_pkg::RESP_SLVERR});
    wr(12'h3FC, 32'hFFFFFFFF); chk({30'h0, bs}, {30'h0, pvis_pkg::RESP_SLVERR});
    for (int i = 0; i < 2; i++) begin
      r = $urandom; wr(pvis_pkg::OFF_ROUTE_A + 12'(4 * i), r); rd(pvis_pkg::OFF_ROUTE_A + 12'(4 * i));
      chk(v, r & (i == 0 ? pvis_pkg::ROUTE_A_MASK : pvis_pkg::ROUTE_B_MASK));
      chk({30'h0, bs}, {30'h0, pvis_pkg::RESP_OKAY});
    end
    $display("test registers done");
    // Edge sources are held high across the clear, so only an edge latch reads back zero.
    r = $urandom | 32'h1; @(posedge aclk);
    {vme_ownership_event, dma_done, pci_bus_error, vme_bus_error, soft_ack_event, mailbox_in, loc_monitor_in} <= r[12:0];
    repeat (3) @(posedge aclk);
    rd(pvis_pkg::OFF_STAT);
    chk(v, {8'h0, r[3:0], r[7:4], 3'h0, r[8], 1'b0, r[9], r[10], r[11], 7'h0, r[12]});
    wr(pvis_pkg::OFF_STAT, pvis_pkg::STAT_MASK); rd(pvis_pkg::OFF_STAT); chk(v, 32'h0);
    {vme_ownership_event, dma_done, pci_bus_error, vme_bus_error, soft_ack_event, mailbox_in, loc_monitor_in} <= '0;
    power_fail_in <= 1'b1; sys_fail_in <= 1'b1;
    wr(pvis_pkg::OFF_STAT, 32'h0000C000); rd(pvis_pkg::OFF_STAT); chk(v, 32'h0000C000);
    power_fail_in <= 1'b0; sys_fail_in <= 1'b0;
    wr(pvis_pkg::OFF_STAT, 32'h0000C000); rd(pvis_pkg::OFF_STAT); chk(v, 32'h0);
    $display("test status done");
    d = 3'($urandom_range(7)); wr(pvis_pkg::OFF_ROUTE_B, {29'h0, d}); wr(pvis_pkg::OFF_PCI_EN, 32'h00000100);
    dma_done <= 1'b1; @(posedge aclk); dma_done <= 1'b0; repeat (3) @(posedge aclk);
    chk({24'h0, pci_irq_out_n}, {24'h0, ~(8'h01 << d)});
    wr(pvis_pkg::OFF_STAT, 32'h00000100); repeat (3) @(posedge aclk); chk({24'h0, pci_irq_out_n}, 32'hFF);
    wr(pvis_pkg::OFF_VME_EN, 32'hFFFFFFFF); repeat (2) @(posedge aclk); chk({27'h0, vme_soft_irq}, 32'h1F);
    rd(pvis_pkg::OFF_VME_EN); chk(v, pvis_pkg::VME_EN_MASK);
    wr(pvis_pkg::OFF_VME_EN, 32'h0); repeat (2) @(posedge aclk); chk({27'h0, vme_soft_irq}, 32'h0);
    rd(pvis_pkg::OFF_VME_STAT); chk(v, 32'hF8000000);
    // A source pulse while the clock enable is low must leave no trace.
    aclken <= 1'b0; dma_done <= 1'b1; @(posedge aclk); dma_done <= 1'b0; @(posedge aclk); aclken <= 1'b1;
    rd(pvis_pkg::OFF_STAT); chk(v, 32'h0);
    aresetn <= 1'b0; repeat (2) @(posedge aclk); aresetn <= 1'b1;
    rd(pvis_pkg::OFF_VME_STAT); chk(v, 32'h0);
    rd(pvis_pkg::OFF_ROUTE_B); chk(v, 32'h0);
    $display("test routing done");
    wr(pvis_pkg::OFF_PCI_EN, 32'h00000008); vme_irq_levels[3] <= 1'b1; repeat (12) @(posedge aclk);
    rd(pvis_pkg::OFF_STAT); chk(v & 32'h8, 32'h8);
    rd(pvis_pkg::OFF_VEC_BASE + 12'h8); chk(v, 32'h84);
    chk({25'h0, iack_req}, 32'h0);
    $display("test acknowledge done");
    end_sim();
  end
endmodule : pci_vme_interrupt_status_map_test
`default_nettype wire
